// >>> fbc_pkg.sv
// Constants and carrier types for the flash bus controller.
// Assumes a 125 MHz system clock and an asynchronous NOR flash outside.
package fbc_pkg;

	localparam int CLK_MHZ         = 125;
	localparam int T_ADDR_ACC_NS   = 100;
	localparam int T_SEL_ACC_NS    = 100;
	localparam int T_PAGE_ACC_NS   = 35;
	localparam int T_RST_PULSE_NS  = 500;
	localparam int T_WR_PULSE_NS   = 35;
	// Least times round up to whole cycles
	localparam int ADDR_ACC_CYC  = (T_ADDR_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int SEL_ACC_CYC   = (T_SEL_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int PAGE_ACC_CYC  = (T_PAGE_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_PULSE_CYC = (T_RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WR_PULSE_CYC  = (T_WR_PULSE_NS * CLK_MHZ + 999) / 1000;
	// Data hold after the write strobe, a chosen margin
	localparam int WR_REC_CYC    = 2;
	localparam int FULL_ACC_CYC  = (ADDR_ACC_CYC > SEL_ACC_CYC) ?
		ADDR_ACC_CYC : SEL_ACC_CYC;

	localparam int ADDR_W       = 22;
	localparam int DATA_W       = 16;
	localparam int WORD_SEL_W   = 2;
	localparam int BUF_MAX_WORDS = 16;
	localparam int CNT_W        = 8;

	typedef enum logic [1:0] {
		FBC_OP_READ,
		FBC_OP_WRITE,
		FBC_OP_RESET
	} fbc_op_t;

	typedef struct packed {
		fbc_op_t             op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} fbc_req_t;

	typedef struct packed {
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic                rst_n;
		logic                accel_hv;
		logic [ADDR_W-1:0]   addr;
	} fbc_pins_t;

endpackage

// >>> fbc_ctrl.sv
// Host controller that drives a NOR flash through its async pins.
// Assumes the flash data bus is a split in/out/enable triple.
module fbc_ctrl #(
	parameter int FULL_CYC  = fbc_pkg::FULL_ACC_CYC,
	parameter int PAGE_CYC  = fbc_pkg::PAGE_ACC_CYC,
	parameter int RST_CYC   = fbc_pkg::RST_PULSE_CYC,
	parameter int WR_CYC    = fbc_pkg::WR_PULSE_CYC,
	parameter int IDLE_CYC  = fbc_pkg::WR_REC_CYC
) (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       clk_en_i,
	// Request side
	input  wire logic                       req_valid_i,
	input  wire fbc_pkg::fbc_req_t          req_i,
	input  wire logic                       accel_en_i,
	output logic                            req_ready_o,
	output logic                            rd_valid_o,
	output logic [fbc_pkg::DATA_W-1:0]      rd_data_o,
	// Flash pins
	output fbc_pkg::fbc_pins_t              pins_o,
	input  wire logic [fbc_pkg::DATA_W-1:0] flash_dq_i,
	output logic [fbc_pkg::DATA_W-1:0]      flash_dq_o,
	output logic                            flash_dq_oe_n_o
);

	// Read waits add two synchroniser cycles to an 8-bit counter
	if (FULL_CYC < 1 || PAGE_CYC < 1 || RST_CYC < 1 || WR_CYC < 1 ||
		IDLE_CYC < 1 || FULL_CYC > 254 || RST_CYC > 255 ||
		PAGE_CYC > FULL_CYC || WR_CYC > 255 || IDLE_CYC > 255)
	begin : g_bad_cycles
		$error("fbc_ctrl: cycle counts out of range");
	end

	typedef enum logic [2:0] {
		FBC_IDLE,
		FBC_READ,
		FBC_WRITE,
		FBC_WREC,
		FBC_RESET
	} fbc_state_t;

	localparam int AW = fbc_pkg::ADDR_W;
	localparam int WS = fbc_pkg::WORD_SEL_W;

	fbc_state_t                  state_r, state_nxt;
	logic [fbc_pkg::CNT_W-1:0]   cnt_r, cnt_nxt;
	logic                        page_ok_r, page_ok_nxt;
	logic [AW-WS-1:0]            page_r, page_nxt;
	fbc_pkg::fbc_pins_t          pins_r, pins_nxt;
	logic                        ready_r, ready_nxt;
	logic                        rv_r, rv_nxt;
	logic [fbc_pkg::DATA_W-1:0]  rd_r, rd_nxt, dq_r, dq_nxt;
	logic                        dq_oe_n_r, dq_oe_n_nxt;
	logic [fbc_pkg::DATA_W-1:0]  dq_s1_r, dq_s2_r, dq_s3_r;
	logic [fbc_pkg::CNT_W-1:0]   rst_len_r;

	function automatic logic [fbc_pkg::CNT_W-1:0] cyc(input int n);
		cyc = fbc_pkg::CNT_W'(n - 1);
	endfunction

	// Request decode
	wire                take     = ready_r & req_valid_i;
	wire [AW-WS-1:0]    req_page = req_i.addr[AW-1:WS];
	wire                same_pg  = page_ok_r & (req_page == page_r);
	wire                cnt_done = (cnt_r == '0);
	// Stable sampled data: second and third stage agree
	wire                dq_ok    = (dq_s2_r == dq_s3_r);

	always_comb
	begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		page_ok_nxt = page_ok_r;
		page_nxt    = page_r;
		pins_nxt    = pins_r;
		ready_nxt   = ready_r;
		rv_nxt      = 1'b0;
		rd_nxt      = rd_r;
		dq_nxt      = dq_r;
		dq_oe_n_nxt = dq_oe_n_r;
		case (state_r)
			FBC_IDLE:
			begin
				if (take)
				begin
					ready_nxt      = 1'b0;
					pins_nxt.addr  = req_i.addr;
					case (req_i.op)
						fbc_pkg::FBC_OP_WRITE:
						begin
							pins_nxt.ce_n  = 1'b0;
							pins_nxt.we_n  = 1'b0;
							pins_nxt.oe_n  = 1'b1;
							dq_nxt         = req_i.data;
							dq_oe_n_nxt    = 1'b0;
							// high voltage only for accel program
							pins_nxt.accel_hv = accel_en_i;
							page_ok_nxt    = 1'b0;
							cnt_nxt        = cyc(WR_CYC);
							state_nxt      = FBC_WRITE;
						end
						fbc_pkg::FBC_OP_RESET:
						begin
							pins_nxt.rst_n = 1'b0;
							pins_nxt.ce_n  = 1'b1;
							pins_nxt.oe_n  = 1'b1;
							pins_nxt.accel_hv = 1'b0;
							page_ok_nxt    = 1'b0;
							cnt_nxt        = cyc(RST_CYC);
							state_nxt      = FBC_RESET;
						end
						default:
						begin
							pins_nxt.ce_n  = 1'b0;
							pins_nxt.oe_n  = 1'b0;
							pins_nxt.we_n  = 1'b1;
							pins_nxt.accel_hv = 1'b0;
							// page hit uses the short wait
							cnt_nxt   = same_pg ? cyc(PAGE_CYC + 2)
								: cyc(FULL_CYC + 2);
							page_nxt    = req_page;
							page_ok_nxt = 1'b1;
							state_nxt   = FBC_READ;
						end
					endcase
				end
				else if (!pins_r.ce_n && pins_r.oe_n == 1'b0)
				begin
					// Hold selected so page state survives idle gaps
					pins_nxt.ce_n = 1'b0;
				end
			end
			FBC_READ:
			begin
				// Extra two cycles cover the input synchroniser
				if (cnt_done)
				begin
					rd_nxt    = dq_s3_r;
					rv_nxt    = dq_ok;
					if (dq_ok)
					begin
						ready_nxt = 1'b1;
						state_nxt = FBC_IDLE;
					end
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			FBC_WRITE:
			begin
				if (cnt_done)
				begin
					// releasing chip enable forces a full access next
					pins_nxt.we_n = 1'b1;
					pins_nxt.ce_n = 1'b1;
					cnt_nxt       = cyc(IDLE_CYC);
					state_nxt     = FBC_WREC;
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			FBC_WREC:
			begin
				if (cnt_done)
				begin
					// drop high voltage before going idle
					pins_nxt.accel_hv = 1'b0;
					dq_oe_n_nxt = 1'b1;
					ready_nxt   = 1'b1;
					state_nxt   = FBC_IDLE;
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			FBC_RESET:
			begin
				if (cnt_done)
				begin
					// device back in array read; caller reissues
					pins_nxt.rst_n = 1'b1;
					ready_nxt      = 1'b1;
					state_nxt      = FBC_IDLE;
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			default:
				state_nxt = FBC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_r   <= FBC_IDLE;
			cnt_r     <= '0;
			page_ok_r <= 1'b0;
			page_r    <= '0;
			pins_r    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
				accel_hv: 1'b0, addr: '0};
			ready_r   <= 1'b0;
			rv_r      <= 1'b0;
			rd_r      <= '0;
			dq_r      <= '0;
			dq_oe_n_r <= 1'b1;
			dq_s1_r   <= '0;
			dq_s2_r   <= '0;
			dq_s3_r   <= '0;
		end
		else if (clk_en_i)
		begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			page_ok_r <= page_ok_nxt;
			page_r    <= page_nxt;
			pins_r    <= pins_nxt;
			ready_r   <= (state_r == FBC_IDLE && !ready_r) ? 1'b1 : ready_nxt;
			rv_r      <= rv_nxt;
			rd_r      <= rd_nxt;
			dq_r      <= dq_nxt;
			dq_oe_n_r <= dq_oe_n_nxt;
			dq_s1_r   <= flash_dq_i;
			dq_s2_r   <= dq_s1_r;
			dq_s3_r   <= dq_s2_r;
		end
	end

	assign req_ready_o     = ready_r;
	assign rd_valid_o      = rv_r;
	assign rd_data_o       = rd_r;
	assign pins_o          = pins_r;
	assign flash_dq_o      = dq_r;
	assign flash_dq_oe_n_o = dq_oe_n_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking fbc_cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Helper: cycles the flash reset pin has stayed low
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			rst_len_r <= '0;
		else if (clk_en_i)
			rst_len_r <= pins_r.rst_n ? '0 : rst_len_r + 1'b1;
	end

	a_write_levels: assert property (
		!pins_r.we_n |-> !pins_r.ce_n && pins_r.oe_n && !dq_oe_n_r)
		else $error("write strobe without proper levels");
	a_no_contention: assert property (
		!dq_oe_n_r |-> pins_r.oe_n)
		else $error("host drives data while flash outputs enabled");
	a_hv_only_write: assert property (
		pins_r.accel_hv |-> state_r inside {FBC_WRITE, FBC_WREC})
		else $error("high voltage outside accelerated program");
	a_reset_width: assert property (
		$rose(pins_r.rst_n) |-> rst_len_r >= RST_CYC)
		else $error("reset pulse shorter than expected");
	a_read_oe_low: assert property (
		state_r == FBC_READ |-> !pins_r.oe_n && !pins_r.ce_n)
		else $error("read without select and output enable");
	a_write_release: assert property (
		state_r == FBC_WREC |-> pins_r.ce_n && !page_ok_r)
		else $error("chip enable not released after write");
	a_ready_idle: assert property (
		req_ready_o |-> state_r == FBC_IDLE)
		else $error("ready outside idle");
	a_valid_pulse: assert property (
		rd_valid_o && clk_en_i |=> !rd_valid_o)
		else $error("read valid held over one cycle");

	c_read: cover property (rd_valid_o);
	c_write: cover property (state_r == FBC_WREC);
	c_reset: cover property ($rose(pins_r.rst_n));
	c_accel: cover property (pins_r.accel_hv);

endmodule

// >>> fbc_flash_model.sv
// Behavioural flash device driven through its pins, timed by the bench clock.
// Assumes pins change just after rising edges and counts match the design.
module fbc_flash_model #(
	parameter int FULL = 6,
	parameter int PAGE = 2
) (
	// Clock and pins
	input  wire logic               clk_i,
	input  wire fbc_pkg::fbc_pins_t pins_i,
	input  wire logic [15:0]        dq_i,
	input  wire logic               host_oe_n_i,
	// Data out and protocol faults
	output logic [15:0]             dq_o,
	output logic                    dq_oe_n_o,
	output logic [7:0]              viol_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Erase, autoselect and command decoding left out: writes program
	// Address held for access time plus 30 ns puts the device to sleep
	localparam int SLEEP = FULL + 4;
	logic [15:0]        mem [int];
	fbc_pkg::fbc_pins_t prv = '1;
	logic [15:0]        dq_r = 16'h0000;
	logic [7:0]         viol_r = 8'h00;
	logic               bypass = 1'b0;
	int                 cnt = 0;
	int                 need = FULL;
	int                 still = 0;
	int                 bad;
	int                 a;
	assign dq_o   = dq_r;
	assign viol_o = viol_r;
	// drive only for a selected read out of reset
	assign dq_oe_n_o = pins_i.ce_n | pins_i.oe_n | ~pins_i.we_n |
		~pins_i.rst_n;
	always @(posedge clk_i)
	begin
		a = int'(pins_i.addr);
		bad = 0;
		prv <= pins_i;
		// bypass mode follows the high voltage on the pin
		bypass <= pins_i.accel_hv;
		// sleep timer ignores the control levels
		still = (pins_i.addr == prv.addr) ? still + 1 : 0;
		// reset aborts, leaves array read, ignores commands
		if (!pins_i.rst_n)
		begin
			cnt = 0;
			need = FULL;
		end
		else
		begin
			if (!pins_i.we_n && (pins_i.ce_n || !pins_i.oe_n))
				bad++;
			if (pins_i.accel_hv && !pins_i.oe_n)
				bad++;
			// voltage must not leave in mid strobe
			if (bypass && !pins_i.accel_hv && !pins_i.we_n)
				bad++;
			// each data write programs, select may drop
			if (pins_i.we_n && !prv.we_n)
				mem[int'(prv.addr)] = dq_i;
			// full time unless same page, select held
			if (pins_i.ce_n || prv.ce_n || !prv.rst_n)
			begin
				cnt = 0;
				need = FULL;
			end
			else if (pins_i.addr != prv.addr)
			begin
				cnt = 0;
				need = (pins_i.addr[21:2] == prv.addr[21:2]) ? PAGE : FULL;
			end
			cnt++;
		end
		// word latched once valid and kept while asleep
		if (cnt >= need)
		begin
			if (still < SLEEP || cnt == need)
				dq_r <= mem.exists(a) ? mem[a] :
					(pins_i.addr[15:0] ^ 16'hA5A5);
		end
		else
			dq_r <= ~dq_r;
		// host and device never drive together
		if (!dq_oe_n_o && !host_oe_n_i)
			bad++;
		viol_r <= viol_r + 8'(bad);
	end
endmodule

// >>> test_flash_async_bus_modes.sv
// Self-checking bench: controller against a behavioural flash device.
// Assumes small access counts shared by design and device model.
module test_flash_async_bus_modes;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FULL = 6;
	localparam int PAGE = 2;
	localparam int RST  = 4;
	logic               clk_i = 0;
	logic               sys_rst_i = 1;
	logic               clk_en_i = 1;
	logic               req_valid_i = 0;
	logic               accel_en_i = 0;
	fbc_pkg::fbc_req_t  req_i = '0;
	fbc_pkg::fbc_pins_t pins_o;
	logic               req_ready_o, rd_valid_o, flash_dq_oe_n_o, m_oe_n;
	logic [15:0]        rd_data_o, flash_dq_o, flash_dq_i, m_dq;
	logic [15:0]        float_r = 16'h5A5A;
	logic [7:0]         viol;
	int                 n_errors = 0, n_compared = 0, seed = 60657;
	int                 lat, rst_lo, hv_seen, i, ad, wa, wd;
	int                 mem [int];

	fbc_ctrl #(.FULL_CYC(FULL), .PAGE_CYC(PAGE), .RST_CYC(RST), .WR_CYC(2))
	uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .accel_en_i(accel_en_i),
		.req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .pins_o(pins_o), .flash_dq_i(flash_dq_i),
		.flash_dq_o(flash_dq_o), .flash_dq_oe_n_o(flash_dq_oe_n_o));
	fbc_flash_model #(.FULL(FULL), .PAGE(PAGE)) dev (.clk_i(clk_i),
		.pins_i(pins_o), .dq_i(flash_dq_i), .host_oe_n_i(flash_dq_oe_n_o),
		.dq_o(m_dq), .dq_oe_n_o(m_oe_n), .viol_o(viol));
	// Undriven bus wanders rather than holding a stale word
	assign flash_dq_i = !flash_dq_oe_n_o ? flash_dq_o :
		!m_oe_n ? m_dq : float_r;
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		float_r <= ~float_r;
		if (pins_o.rst_n === 1'b0)
			rst_lo++;
		if (pins_o.accel_hv === 1'b1)
			hv_seen++;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic op(fbc_pkg::fbc_op_t o, int a, int d, logic acc);
		int k;
		k = 0;
		req_valid_i <= 1'b1;
		req_i <= '{o, a[21:0], d[15:0]};
		accel_en_i <= acc;
		do begin @(posedge clk_i); k++; end
		while (req_ready_o !== 1'b1 && k < 200);
		req_valid_i <= 1'b0;
		lat = 0;
		do begin @(posedge clk_i); lat++; end
		while ((o == fbc_pkg::FBC_OP_READ ? rd_valid_o : req_ready_o) !== 1'b1
			&& lat < 500);
		if (k >= 200 || lat >= 500)
		begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic rd(int a);
		op(fbc_pkg::FBC_OP_READ, a, 0, 1'b0);
		chk("read data", rd_data_o,
			mem.exists(a) ? mem[a] : (a & 'hFFFF) ^ 'hA5A5);
	endtask

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		ad = $random(seed) & 'h3FFFFC;
		rd(ad);
		chk("first access", lat >= FULL + 3, 1);
		for (i = 1; i < 4; i++)
		begin
			rd(ad + i);
			chk("page access", lat < FULL + 3, 1);
		end
		rd(ad + 4);
		chk("next page", lat >= FULL + 3, 1);
		wa = $random(seed) & 'h3FFFF0;
		for (i = 0; i < 16; i++)
		begin
			wd = $random(seed) & 'hFFFF;
			hv_seen = 0;
			op(fbc_pkg::FBC_OP_WRITE, wa + i, wd, i[0]);
			mem[wa + i] = wd;
			chk("high voltage", hv_seen > 0, i[0]);
		end
		for (i = 0; i < 16; i++)
		begin
			rd(wa + i);
			if (i == 0)
				chk("read after write", lat >= FULL + 3, 1);
		end
		rst_lo = 0;
		op(fbc_pkg::FBC_OP_RESET, 0, 0, 1'b0);
		chk("reset width", rst_lo >= RST, 1);
		rd(ad + 1);
		chk("read after reset", lat >= FULL + 3, 1);
		fork
			rd(ad + 2);
			begin
				repeat (2) @(posedge clk_i);
				clk_en_i <= 1'b0;
				repeat (3) @(posedge clk_i);
				clk_en_i <= 1'b1;
			end
		join
		chk("frozen read", lat >= PAGE + 6, 1);
		chk("pin faults", viol, 0);
		conclude();
	end
endmodule
